// File: include/shift_mode_defs.svh
// Purpose: constants of the shift and mode-select decoder
// Assumes: 16-bit instructions and operands
// Notes:   register indices are word indices on the plain register port
`ifndef SHIFT_MODE_DEFS_SVH
`define SHIFT_MODE_DEFS_SVH
`define OP_SHRS_R     10'h0B7
`define OP_SHRS_I     9'h04F
`define OP_SEL_BASE   15'h1B05
`define OP_SEL_SPI    15'h1B04
`define OP_FBK        13'h06C8
`define OP_LOAD_BASE  10'h0D0
`define OP_ADC_MODE   13'h06AD
`define REG_DRV_A     9'h184
`define REG_DRV_B     9'h185
`define REG_DRV_C     9'h186
`define REG_DRV_D     9'h187
`define REG_CUR_1     9'h188
`define REG_CUR_2     9'h189
`define REG_STATUS    9'h18A
`define RST_CFG       16'h0000
`define DIAG_OFF      2'h2
`define DIAG_ON       2'h3
`endif

// File: include/shift_mode_pkg.sv
// Purpose: types of the shift and mode-select decoder
// Assumes: nothing beyond the defs header
// Notes:   flags travel together as one struct
package shift_mode_pkg;
  typedef struct packed {
    logic shifted_out_bit_flag;
    logic precision_loss_flag;
    logic overflow_flag;
  } cond_flags_t;
  typedef struct packed {
    logic       base_source_field;
    logic       serial_address_source_field;
    logic       fbk_battery;
    logic       auto_diag;
    logic [3:0] conversion_enable_field;
    logic [5:0] base_value_field;
  } mode_state_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT} shift_state_t;
endpackage

// File: hw/shift_mode_core.sv
// Purpose: decode and run signed right shifts and mode-select instructions
// Assumes: one instruction offered per cycle while no shift runs; stall_out falls a cycle before the engine is free
// Notes:   drive right bits 0 and 1 of cfg a..d, both set, are the right of core 0..3
`timescale 1ns/1ps
`include "shift_mode_defs.svh"
module shift_mode_core
(
  input  wire logic                       core_clk_in,
  input  wire logic                       resetn_in,
  input  wire logic                       instr_valid_in,
  input  wire logic [15:0]                instr_in,
  input  wire logic [1:0]                 core_id_in,
  input  wire logic [7:0][15:0]           alu_operand_set_in,
  output logic                            stall_out,
  output logic                            wr_en_out,
  output logic [2:0]                      wr_sel_out,
  output logic [15:0]                     wr_data_out,
  output shift_mode_pkg::cond_flags_t     flags_out,
  output shift_mode_pkg::mode_state_t     mode_out,
  input  wire logic [8:0]                 reg_addr_in,
  input  wire logic [15:0]                reg_wdata_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  output logic [15:0]                     reg_rdata_out
);
  shift_mode_pkg::shift_state_t st_r;
  shift_mode_pkg::cond_flags_t  flags_r;
  shift_mode_pkg::mode_state_t  mode_r;
  logic [15:0] acc_r;
  logic [3:0]  cnt_r;
  logic [2:0]  tgt_r;
  logic        imm_r;
  logic [3:0][15:0] drv_r;
  logic [1:0][15:0] cur_r;
  logic [15:0] rdata_r;
  logic        take;
  logic        dec_r;
  logic        dec_i;
  logic [3:0]  amount;
  logic        fbk_ok;
  logic [1:0]  blk;
  logic [15:0] shifted;
  // ==========================================
  // decode
  function automatic logic [15:0] asr1(input logic [15:0] v);
    asr1 = {v[15], v[15:1]};
  endfunction
  assign take  = instr_valid_in && (st_r == shift_mode_pkg::ST_IDLE);
  assign dec_r = take && instr_in[15:6] == `OP_SHRS_R;
  assign dec_i = take && instr_in[15:7] == `OP_SHRS_I;
  // amount register counts keep only their low 4 bits, so at most 15 bits of a 16-bit operand
  assign amount = dec_r ? alu_operand_set_in[instr_in[5:3]][3:0]
                        : instr_in[6:3];
  assign fbk_ok = drv_r[core_id_in][0] && drv_r[core_id_in][1];
  assign blk = {core_id_in[1] ^ instr_in[1], core_id_in[0] ^ instr_in[0]};
  assign shifted = asr1(acc_r);
  assign stall_out = (st_r == shift_mode_pkg::ST_SHIFT) && cnt_r > 4'h1;
  // ==========================================
  // shift engine, one bit per core cycle
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_r    <= shift_mode_pkg::ST_IDLE;
      acc_r   <= 16'h0000;
      cnt_r   <= 4'h0;
      tgt_r   <= 3'h0;
      imm_r   <= 1'b0;
      flags_r <= '0;
    end
    else if ((dec_r || dec_i) && amount != 4'h0)
    begin
      st_r  <= shift_mode_pkg::ST_SHIFT;
      acc_r <= alu_operand_set_in[instr_in[2:0]];
      cnt_r <= amount;
      tgt_r <= instr_in[2:0];
      imm_r <= dec_i;
      flags_r <= '0;
    end
    else if (st_r == shift_mode_pkg::ST_SHIFT)
    begin
      acc_r <= shifted;
      cnt_r <= cnt_r - 4'h1;
      flags_r.shifted_out_bit_flag <= acc_r[0];
      if (imm_r)
        flags_r.overflow_flag <= flags_r.overflow_flag | acc_r[0];
      else
        flags_r.precision_loss_flag <=
          flags_r.precision_loss_flag | acc_r[0];
      if (cnt_r == 4'h1)
        st_r <= shift_mode_pkg::ST_IDLE;
    end
  end
  // ==========================================
  // write-back of the shifted operand
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wr_en_out   <= 1'b0;
      wr_sel_out  <= 3'h0;
      wr_data_out <= 16'h0000;
    end
    else
    begin
      wr_en_out <= (st_r == shift_mode_pkg::ST_SHIFT) && cnt_r == 4'h1;
      wr_sel_out  <= tgt_r;
      wr_data_out <= shifted;
    end
  end
  // ==========================================
  // mode selects
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      mode_r <= '0;
    else if (take)
    begin
      if (instr_in[15:1] == `OP_SEL_BASE)
        mode_r.base_source_field <= instr_in[0];
      if (instr_in[15:1] == `OP_SEL_SPI)
        mode_r.serial_address_source_field <= instr_in[0];
      if (instr_in[15:6] == `OP_LOAD_BASE)
        mode_r.base_value_field <= instr_in[5:0];
      // without the right the setting simply stays
      if (instr_in[15:3] == `OP_FBK && fbk_ok)
      begin
        mode_r.fbk_battery <= instr_in[2];
        if (instr_in[1:0] == `DIAG_ON)
          mode_r.auto_diag <= 1'b1;
        else if (instr_in[1:0] == `DIAG_OFF)
          mode_r.auto_diag <= 1'b0;
      end
      if (instr_in[15:3] == `OP_ADC_MODE && cur_r[0][{core_id_in, blk}])
        mode_r.conversion_enable_field[blk] <= instr_in[2];
    end
  end
  assign flags_out = flags_r;
  assign mode_out  = mode_r;
  // ==========================================
  // register port
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      drv_r <= {4{`RST_CFG}};
      cur_r <= {2{`RST_CFG}};
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        `REG_DRV_A: drv_r[0] <= reg_wdata_in;
        `REG_DRV_B: drv_r[1] <= reg_wdata_in;
        `REG_DRV_C: drv_r[2] <= reg_wdata_in;
        `REG_DRV_D: drv_r[3] <= reg_wdata_in;
        `REG_CUR_1: cur_r[0] <= reg_wdata_in;
        `REG_CUR_2: cur_r[1] <= reg_wdata_in;
        default: ;
      endcase
    end
  end
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rdata_r <= 16'h0000;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        `REG_DRV_A: rdata_r <= drv_r[0];
        `REG_DRV_B: rdata_r <= drv_r[1];
        `REG_DRV_C: rdata_r <= drv_r[2];
        `REG_DRV_D: rdata_r <= drv_r[3];
        `REG_CUR_1: rdata_r <= cur_r[0];
        `REG_CUR_2: rdata_r <= cur_r[1];
        // status is 18 bits wide; the two source selects fall off the top
        `REG_STATUS: rdata_r <= 16'({mode_r, flags_r, stall_out});
        default:    rdata_r <= 16'h0000;
      endcase
    end
    else
      rdata_r <= 16'h0000;
  end
  assign reg_rdata_out = rdata_r;
  // ==========================================
  // checks
  a_sign_kept: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    st_r == shift_mode_pkg::ST_SHIFT |=> acc_r[15] == $past(acc_r[15]))
    else $error("sign bit changed during shift");
  a_shift_len: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (dec_i && instr_in[6:3] == 4'h3) |=> stall_out [*2] ##1 !stall_out)
    else $error("immediate shift length wrong");
  a_base_load: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    take && instr_in[15:6] == `OP_LOAD_BASE |=>
      mode_r.base_value_field == $past(instr_in[5:0]))
    else $error("base value not loaded");
  a_fbk_denied: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    take && instr_in[15:3] == `OP_FBK && !fbk_ok |=> $stable(mode_r.fbk_battery))
    else $error("feedback changed without right");
  a_zero_shift: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    (dec_r || dec_i) && amount == 4'h0 |=> st_r == shift_mode_pkg::ST_IDLE)
    else $error("zero shift stalled");
  a_wb_once: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    wr_en_out |=> !wr_en_out)
    else $error("write-back repeated");
  a_diag_on: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    take && instr_in[15:3] == `OP_FBK && fbk_ok && instr_in[1:0] == 2'h3
      |=> mode_r.auto_diag)
    else $error("diagnosis not enabled");
  a_base_sel: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    take && instr_in[15:1] == `OP_SEL_BASE |=>
      mode_r.base_source_field == $past(instr_in[0]))
    else $error("base source not selected");
endmodule

// File: bench/shift_mode_core_test.sv
// Purpose: self-checking bench of the shift and mode-select decoder
// Assumes: core 0 executes; rights are granted over the register port
// Notes:   expected results are rebuilt here from the operand values
`timescale 1ns/1ps
`include "shift_mode_defs.svh"
module shift_mode_core_test;
  logic                        core_clk_in = 1'b0;
  logic                        resetn_in = 1'b0;
  logic                        instr_valid_in = 1'b0;
  logic [15:0]                 instr_in = 16'h0000;
  logic [7:0][15:0]            ops = '0;
  logic [8:0]                  reg_addr_in = 9'h000;
  logic [15:0]                 reg_wdata_in = 16'h0000;
  logic                        reg_wr_in = 1'b0;
  logic                        reg_rd_in = 1'b0;
  logic                        stall_out;
  logic                        wr_en_out;
  logic [2:0]                  wr_sel_out;
  logic [15:0]                 wr_data_out;
  logic [15:0]                 reg_rdata_out;
  shift_mode_pkg::cond_flags_t flags_out;
  shift_mode_pkg::mode_state_t mode_out;
  shift_mode_pkg::mode_state_t em;
  int                          error_cnt = 0;
  int                          n_checks = 0;
  logic [2:0]                  fbt [4] = '{3'b111, 3'b000, 3'b101, 3'b010};

  always #50 core_clk_in = ~core_clk_in;

  shift_mode_core i_shift_mode_core (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .core_id_in(2'b00), .alu_operand_set_in(ops),
    .stall_out(stall_out), .wr_en_out(wr_en_out),
    .wr_sel_out(wr_sel_out), .wr_data_out(wr_data_out),
    .flags_out(flags_out), .mode_out(mode_out),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out));

  // ==========================================================
  // access tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge core_clk_in) reg_wr_in <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in) reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [15:0] e);
    @(posedge core_clk_in) reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in) reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, e);
  endtask
  // mode ops compare the whole state, so side effects are seen too
  task automatic op(input logic [15:0] w);
    @(posedge core_clk_in) instr_valid_in <= 1'b1;
    instr_in <= w;
    @(posedge core_clk_in) instr_valid_in <= 1'b0;
    @(posedge core_clk_in);
    #1 chk({2'h0, mode_out}, {2'h0, em});
  endtask
  task automatic shift(input logic [15:0] w, input int n, input logic imm);
    logic [15:0] v;
    logic [15:0] lost;
    int          cnt;
    @(posedge core_clk_in) instr_valid_in <= 1'b1;
    instr_in <= w;
    v    = ops[w[2:0]];
    lost = v & ((16'h0001 << n) - 16'h0001);
    @(posedge core_clk_in) instr_valid_in <= 1'b0;
    cnt = 0;
    do
    begin
      @(posedge core_clk_in);
      #1 cnt++;
      if (cnt == 1 && n > 2) chk({15'h0, stall_out}, 16'h0001);
    end
    while (wr_en_out !== 1'b1 && cnt < 40);
    chk(cnt[15:0], n[15:0]);
    chk({13'h0, wr_sel_out}, {13'h0, w[2:0]});
    chk(wr_data_out, 16'($signed(v) >>> n));
    chk({14'h0, flags_out.shifted_out_bit_flag,
         imm ? flags_out.overflow_flag : flags_out.precision_loss_flag},
        {14'h0, v[n-1], |lost});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // watchdog: a hung shift must not stall the run forever
  initial
  begin
    #(3000 * 100);
    error_cnt++;
    tally_and_finish();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    em = '0;
    repeat (5) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    chk({2'h0, mode_out}, 16'h0000);
    rd(`REG_DRV_A, `RST_CFG);
    rd(9'h100, 16'h0000);
    op({`OP_FBK, 3'b111});
    wr(`REG_DRV_A, 16'h0003);
    rd(`REG_DRV_A, 16'h0003);
    foreach (fbt[i])
    begin
      em.fbk_battery = fbt[i][2];
      em.auto_diag   = fbt[i][1] ? fbt[i][0] : em.auto_diag;
      op({`OP_FBK, fbt[i]});
    end
    op({`OP_ADC_MODE, 3'b101});
    wr(`REG_CUR_1, 16'h0002);
    em.conversion_enable_field[1] = 1'b1;
    op({`OP_ADC_MODE, 3'b101});
    op({`OP_ADC_MODE, 3'b100});
    wr(`REG_CUR_1, 16'h000F);
    for (int t = 0; t < 4; t++)
    begin
      em.conversion_enable_field[t] = ~t[0];
      op({`OP_ADC_MODE, ~t[0], t[1:0]});
    end
    em.base_value_field = 6'h2A;
    op({`OP_LOAD_BASE, 6'h2A});
    em.base_source_field = 1'b1;
    op({`OP_SEL_BASE, 1'b1});
    em.serial_address_source_field = 1'b1;
    op({`OP_SEL_SPI, 1'b1});
    em.base_source_field = 1'b0;
    op({`OP_SEL_BASE, 1'b0});
    @(posedge core_clk_in);
    ops[1] <= 16'h8006;
    ops[2] <= 16'h0013;
    ops[3] <= 16'h9ABD;
    ops[5] <= 16'h7FF5;
    shift({`OP_SHRS_I, 4'h2, 3'd1}, 2, 1'b1);
    shift({`OP_SHRS_R, 3'd2, 3'd5}, 3, 1'b0);
    shift({`OP_SHRS_I, 4'hF, 3'd3}, 15, 1'b1);
    shift({`OP_SHRS_I, 4'h1, 3'd5}, 1, 1'b1);
    rd(`REG_STATUS, 16'h16AA);
    tally_and_finish();
  end
endmodule
